// File: rtl/fpb_consts.svh
// Constants for the front-panel button, alarm and indicator block.
`ifndef FPB_CONSTS_SVH
`define FPB_CONSTS_SVH

// Register byte offsets.
`define FPB_REG_CTRL        8'h00
`define FPB_REG_STATE       8'h04
`define FPB_REG_CONFIG      8'h08
`define FPB_REG_OVERTEMP    8'h0c
`define FPB_REG_CLOCK       8'h10
`define FPB_REG_UNIT_ID     8'h14
`define FPB_REG_UNIT_SERIAL 8'h18
`define FPB_REG_HEAD_ID     8'h1c
`define FPB_REG_HEAD_SERIAL 8'h20
`define FPB_REG_SNAP_TIME   8'h24
`define FPB_REG_SNAP_ENV    8'h28
`define FPB_REG_UPLOAD      8'h2c
`define FPB_REG_LOG_COUNT   8'h30

// Control register bit positions (write-one pulses).
`define FPB_CTRL_STATUS_REQ 0
`define FPB_CTRL_UPLOAD_RST 1

// Reset values.
`define FPB_OVERTEMP_RST    8'h46
`define FPB_RATE_RST        16'h000a
`define FPB_CHAN_RST        8'h01

// Clock and base tick.
`define FPB_CLK_NS          10
`define FPB_TICK_NS         1000000

// Times in milliseconds.
`define FPB_DEBOUNCE_MS     20
`define FPB_LONG_MS         2000
`define FPB_ACK_MS          60
`define FPB_BATT_PERIOD_MS  5000
`define FPB_BATT_ON_MS      20
`define FPB_TEMP_PERIOD_MS  1500
`define FPB_TEMP_ON_MS      150
`define FPB_FAULT_PERIOD_MS 200
`define FPB_FAULT_ON_MS     100
`define FPB_LED_PERIOD_MS   1000

// Words of unit configuration sent ahead of the run data on upload.
`define FPB_UPLOAD_CFG_WORDS 4

`endif

// File: rtl/fpb_pkg.sv
// Types shared by the front-panel block.
package fpb_pkg;

  typedef enum logic [1:0] {
    FPB_OFF,
    FPB_STANDBY,
    FPB_RUN
  } fpb_mode_t;

  typedef enum logic [1:0] {
    FPB_ALM_BATT,
    FPB_ALM_TEMP,
    FPB_ALM_FAULT
  } fpb_alarm_t;

endpackage : fpb_pkg

// File: rtl/fpb_button.sv
// Pushbutton debouncer and short/long press classifier.
`timescale 1ns/1ps
`include "fpb_consts.svh"
module fpb_button #(
  parameter int DEBOUNCE_MS = `FPB_DEBOUNCE_MS,
  parameter int LONG_MS     = `FPB_LONG_MS
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ms_tick,
  input  wire logic button_in,
  output logic      held,
  output logic      short_press,
  output logic      long_press,
  output logic      long_done
);
  logic [15:0] stable_cnt_reg;
  logic [15:0] hold_cnt_reg;
  logic        held_q;

  // A level change must persist for the whole debounce time before it counts.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held           <= 1'b0;
      stable_cnt_reg <= 16'h0000;
    end else if (button_in == held) begin
      stable_cnt_reg <= 16'h0000;
    end else if (ms_tick) begin
      if (stable_cnt_reg == 16'(DEBOUNCE_MS - 1)) begin
        held           <= button_in;
        stable_cnt_reg <= 16'h0000;
      end else begin
        stable_cnt_reg <= stable_cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt_reg <= 16'h0000;
      long_done    <= 1'b0;
      long_press   <= 1'b0;
      short_press  <= 1'b0;
    end else begin
      long_press  <= 1'b0;
      short_press <= 1'b0;
      if (!held) begin
        hold_cnt_reg <= 16'h0000;
        long_done    <= 1'b0;
        short_press  <= (hold_cnt_reg != 16'h0000 || stable_cnt_reg == 16'h0000) && !long_done
                        && held_q;
      end else if (ms_tick && !long_done) begin
        if (hold_cnt_reg == 16'(LONG_MS - 1)) begin
          long_done  <= 1'b1;
          long_press <= 1'b1;
        end else begin
          hold_cnt_reg <= hold_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // Release edge detector on the debounced level.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_q <= 1'b0;
    end else begin
      held_q <= held;
    end
  end

endmodule : fpb_button

// File: rtl/fpb_top.sv
// Front-panel controller: button modes, beeper alarms, memory-fill LED and host status port.
`timescale 1ns/1ps
`include "fpb_consts.svh"
module fpb_top #(
  parameter int          TICK_CYCLES = `FPB_TICK_NS / `FPB_CLK_NS,
  parameter int          LONG_MS     = `FPB_LONG_MS,
  parameter logic [7:0]  UNIT_TYPE   = 8'h01,        // Arbitrary value.
  parameter logic [7:0]  UNIT_FW_REV = 8'h10,        // Arbitrary value.
  parameter logic [31:0] UNIT_SERIAL = 32'h00000001  // Arbitrary value.
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                button_in,
  input  wire logic                batt_low,
  input  wire logic                fault,
  input  wire logic [7:0]          temp_c,
  input  wire logic [15:0]         batt_mv,
  input  wire logic [7:0]          mem_fill,
  input  wire logic                mem_full,
  input  wire logic [7:0]          head_type,
  input  wire logic [7:0]          head_fw_rev,
  input  wire logic [7:0]          head_channels,
  input  wire logic [31:0]         head_serial,
  input  wire logic [15:0]         log_count,
  input  wire logic [31:0]         log_rd_data,
  output logic [15:0]              log_rd_addr,
  output fpb_pkg::fpb_mode_t       mode,
  output logic                     power_en,
  output logic                     erase_log,
  output logic                     beeper,
  output logic                     led_red,
  output logic                     led_green
);
  import fpb_pkg::*;

  localparam int PERIOD_MS [3] = '{`FPB_BATT_PERIOD_MS, `FPB_TEMP_PERIOD_MS, `FPB_FAULT_PERIOD_MS};
  localparam int ON_MS     [3] = '{`FPB_BATT_ON_MS, `FPB_TEMP_ON_MS, `FPB_FAULT_ON_MS};

  // Byte-lane merge, used by every writable register.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) res[b*8 +: 8] = nw[b*8 +: 8];
    end
    return res;
  endfunction : merge

  // Millisecond and second ticks.
  logic [31:0] tick_cnt_reg;
  logic        ms_tick;
  logic [9:0]  ms_in_sec_reg;
  logic        sec_tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg  <= 32'h00000000;
      ms_tick       <= 1'b0;
      ms_in_sec_reg <= 10'h000;
      sec_tick      <= 1'b0;
    end else begin
      ms_tick  <= (tick_cnt_reg == 32'(TICK_CYCLES - 1));
      sec_tick <= 1'b0;
      tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1)) ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
      if (ms_tick) begin
        ms_in_sec_reg <= (ms_in_sec_reg == 10'h3e7) ? 10'h000 : ms_in_sec_reg + 10'h001;
        sec_tick      <= (ms_in_sec_reg == 10'h3e7);
      end
    end
  end

  // Button classification.
  logic held;
  logic short_press;
  logic long_press;
  logic long_done;

  fpb_button #(
    .DEBOUNCE_MS (`FPB_DEBOUNCE_MS),
    .LONG_MS     (LONG_MS)
  ) u_button (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ms_tick     (ms_tick),
    .button_in   (button_in),
    .held        (held),
    .short_press (short_press),
    .long_press  (long_press),
    .long_done   (long_done)
  );

  // Operating mode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode      <= FPB_OFF;
      erase_log <= 1'b0;
      power_en  <= 1'b0;
    end else begin
      erase_log <= 1'b0;
      if (long_press && mode != FPB_OFF) begin
        mode <= FPB_OFF;
      end else if (short_press) begin
        unique case (mode)
          FPB_OFF: begin
            mode <= FPB_STANDBY;
          end
          FPB_STANDBY: begin
            mode      <= FPB_RUN;
            erase_log <= 1'b1;
          end
          FPB_RUN: begin
            mode <= FPB_STANDBY;
          end
        endcase
      end
      power_en <= (mode != FPB_OFF);
    end
  end

  // Host-visible configuration and clock.
  logic [15:0] rate_reg;
  logic [7:0]  chan_reg;
  logic [7:0]  overtemp_reg;
  logic [31:0] clock_reg;
  logic [31:0] snap_time_reg;
  logic [31:0] snap_env_reg;
  logic        snap_valid_reg;
  logic [15:0] upload_idx_reg;
  logic        over_temp;

  assign over_temp = (temp_c > overtemp_reg);

  // Alarm pattern generators; each restarts when its condition appears so the first beep is prompt.
  logic [2:0]  alarm_cond;
  logic [2:0]  alarm_on;
  assign alarm_cond[FPB_ALM_BATT]  = batt_low;
  assign alarm_cond[FPB_ALM_TEMP]  = over_temp;
  assign alarm_cond[FPB_ALM_FAULT] = fault;

  for (genvar i = 0; i < 3; i++) begin : g_alarm
    logic [12:0] cnt_reg;
    always_ff @(posedge aclk) begin
      if (!aresetn || !alarm_cond[i]) begin
        cnt_reg <= 13'h0000;
      end else if (ms_tick) begin
        cnt_reg <= (cnt_reg == 13'(PERIOD_MS[i] - 1)) ? 13'h0000 : cnt_reg + 13'h0001;
      end
    end
    assign alarm_on[i] = alarm_cond[i] && (cnt_reg < 13'(ON_MS[i]));
  end

  // Acknowledge tone after every short press; after a long press only for what is left of 60 ms once the button is released.
  logic [7:0] ack_cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_cnt_reg <= 8'h00;
    end else if (short_press || long_press) begin
      ack_cnt_reg <= 8'(`FPB_ACK_MS);
    end else if (ms_tick && ack_cnt_reg != 8'h00) begin
      ack_cnt_reg <= ack_cnt_reg - 8'h01;
    end
  end

  // The hold tone runs from the debounced press until the long press is taken; the silence is the cue.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      beeper <= 1'b0;
    end else if (held) begin
      beeper <= !long_done;
    end else if (ack_cnt_reg != 8'h00) begin
      beeper <= 1'b1;
    end else if (mode == FPB_OFF) begin
      beeper <= 1'b0;
    end else if (alarm_cond[FPB_ALM_FAULT]) begin
      beeper <= alarm_on[FPB_ALM_FAULT];
    end else if (alarm_cond[FPB_ALM_TEMP]) begin
      beeper <= alarm_on[FPB_ALM_TEMP];
    end else begin
      beeper <= alarm_on[FPB_ALM_BATT];
    end
  end

  // Indicator: fixed period, on-time proportional to fill.
  logic [9:0]  led_cnt_reg;
  logic [17:0] fill_product;
  logic [9:0]  led_on_ms;
  logic        led_lit;

  assign fill_product = 18'(mem_fill) * 18'(`FPB_LED_PERIOD_MS);
  assign led_on_ms    = fill_product[17:8];
  assign led_lit      = mem_full || (led_cnt_reg < led_on_ms);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_cnt_reg <= 10'h000;
    end else if (ms_tick) begin
      led_cnt_reg <= (led_cnt_reg == 10'(`FPB_LED_PERIOD_MS - 1)) ? 10'h000 : led_cnt_reg + 10'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || mode == FPB_OFF) begin
      led_red   <= 1'b0;
      led_green <= 1'b0;
    end else if (fault) begin
      led_red   <= (mode == FPB_STANDBY) && alarm_on[FPB_ALM_FAULT];
      led_green <= (mode == FPB_RUN) && alarm_on[FPB_ALM_FAULT];
    end else begin
      led_red   <= (mode == FPB_STANDBY) && led_lit;
      led_green <= (mode == FPB_RUN) && led_lit;
    end
  end

  // AXI4-Lite write channel: address and data are taken independently, the write acts once both are held.
  logic [7:0]  wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic [3:0]  wr_strb_reg;
  logic        have_aw_reg;
  logic        have_w_reg;
  logic        do_write;
  logic        wr_mapped;

  assign do_write = have_aw_reg && have_w_reg && !s_axi_bvalid;
  assign wr_mapped = (wr_addr_reg <= `FPB_REG_LOG_COUNT) && (wr_addr_reg[1:0] == 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      have_aw_reg   <= 1'b0;
      have_w_reg    <= 1'b0;
      wr_addr_reg   <= 8'h00;
      wr_data_reg   <= 32'h00000000;
      wr_strb_reg   <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !have_aw_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !have_w_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw_reg <= 1'b1;
        wr_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w_reg  <= 1'b1;
        wr_data_reg <= s_axi_wdata;
        wr_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        have_aw_reg  <= 1'b0;
        have_w_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers; the clock keeps counting seconds between host writes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_reg     <= `FPB_RATE_RST;
      chan_reg     <= `FPB_CHAN_RST;
      overtemp_reg <= `FPB_OVERTEMP_RST;
      clock_reg    <= 32'h00000000;
    end else begin
      if (sec_tick) clock_reg <= clock_reg + 32'h00000001;
      if (do_write) begin
        unique case (wr_addr_reg)
          `FPB_REG_CONFIG: begin
            {chan_reg, rate_reg} <= 24'(merge({8'h00, chan_reg, rate_reg}, wr_data_reg, wr_strb_reg));
          end
          `FPB_REG_OVERTEMP: begin
            overtemp_reg <= 8'(merge({24'h000000, overtemp_reg}, wr_data_reg, wr_strb_reg));
          end
          `FPB_REG_CLOCK: begin
            clock_reg <= merge(clock_reg, wr_data_reg, wr_strb_reg);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // A status request freezes time, temperature and battery so the host reads one coherent set.
  logic ctrl_wr;
  assign ctrl_wr = do_write && (wr_addr_reg == `FPB_REG_CTRL) && wr_strb_reg[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snap_time_reg  <= 32'h00000000;
      snap_env_reg   <= 32'h00000000;
      snap_valid_reg <= 1'b0;
    end else if (ctrl_wr && wr_data_reg[`FPB_CTRL_STATUS_REQ]) begin
      snap_time_reg  <= clock_reg;
      snap_env_reg   <= {batt_mv, 8'h00, temp_c};
      snap_valid_reg <= 1'b1;
    end
  end

  // AXI4-Lite read channel: one request at a time, data registered one cycle after the address.
  logic [31:0] rd_word;
  logic        rd_mapped;
  logic        upload_rd;

  always_comb begin
    rd_word   = 32'h00000000;
    rd_mapped = 1'b1;
    unique case (s_axi_araddr)
      `FPB_REG_CTRL:        rd_word = 32'h00000000;
      `FPB_REG_STATE:       rd_word = {20'h00000, mem_full, fault, over_temp, batt_low, snap_valid_reg,
                                       held, power_en, 3'h0, 2'(mode)};
      `FPB_REG_CONFIG:      rd_word = {8'h00, chan_reg, rate_reg};
      `FPB_REG_OVERTEMP:    rd_word = {24'h000000, overtemp_reg};
      `FPB_REG_CLOCK:       rd_word = clock_reg;
      `FPB_REG_UNIT_ID:     rd_word = {16'h0000, UNIT_FW_REV, UNIT_TYPE};
      `FPB_REG_UNIT_SERIAL: rd_word = UNIT_SERIAL;
      `FPB_REG_HEAD_ID:     rd_word = {8'h00, head_channels, head_fw_rev, head_type};
      `FPB_REG_HEAD_SERIAL: rd_word = head_serial;
      `FPB_REG_SNAP_TIME:   rd_word = snap_time_reg;
      `FPB_REG_SNAP_ENV:    rd_word = snap_env_reg;
      `FPB_REG_UPLOAD: begin
        unique case (upload_idx_reg)
          16'h0000: rd_word = {8'h00, chan_reg, rate_reg};
          16'h0001: rd_word = {24'h000000, overtemp_reg};
          16'h0002: rd_word = {16'h0000, UNIT_FW_REV, UNIT_TYPE};
          16'h0003: rd_word = {8'h00, head_channels, head_fw_rev, head_type};
          default:  rd_word = log_rd_data;
        endcase
      end
      `FPB_REG_LOG_COUNT:   rd_word = {16'h0000, log_count};
      default:              rd_mapped = 1'b0;
    endcase
  end

  assign upload_rd = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `FPB_REG_UPLOAD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_mapped ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Upload cursor: each read of the upload word advances it; the log address follows it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upload_idx_reg <= 16'h0000;
    end else if (ctrl_wr && wr_data_reg[`FPB_CTRL_UPLOAD_RST]) begin
      upload_idx_reg <= 16'h0000;
    end else if (upload_rd) begin
      upload_idx_reg <= upload_idx_reg + 16'h0001;
    end
  end

  // Log memory must present log_rd_data within one cycle of a new address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      log_rd_addr <= 16'h0000;
    end else if (upload_idx_reg >= 16'(`FPB_UPLOAD_CFG_WORDS)) begin
      log_rd_addr <= upload_idx_reg - 16'(`FPB_UPLOAD_CFG_WORDS);
    end else begin
      log_rd_addr <= 16'h0000;
    end
  end

endmodule : fpb_top

// File: testbench/fpb_top_asserts.sv
// Port checker of the front-panel controller.
`timescale 1ns/1ps
module fpb_top_chk (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire fpb_pkg::fpb_mode_t mode,
  input wire logic               power_en,
  input wire logic               erase_log,
  input wire logic               led_red,
  input wire logic               led_green
);
  import fpb_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_POWER: assert property (power_en == ($past(mode) != FPB_OFF))
    else $error("power enable does not follow mode");
  AST_ERASE_SET: assert property ($past(mode) == FPB_STANDBY && mode == FPB_RUN |-> erase_log)
    else $error("no erase pulse on entry to run");
  AST_ERASE_ONLY: assert property (erase_log |-> mode == FPB_RUN && $past(mode) == FPB_STANDBY)
    else $error("erase pulse outside standby to run");
  AST_OFF_EXIT: assert property (mode == FPB_OFF |=> mode != FPB_RUN)
    else $error("off went straight to run");
  AST_GREEN: assert property (led_green |-> mode == FPB_RUN || $past(mode) == FPB_RUN)
    else $error("green lit outside run");
  AST_RED: assert property (led_red |-> mode == FPB_STANDBY || $past(mode) == FPB_STANDBY)
    else $error("red lit outside standby");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WR_LAT: assert property (s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready longer than one cycle");
endmodule : fpb_top_chk
bind fpb_top fpb_top_chk chk_u (.*);

// File: testbench/fpb_operator.sv
// Operator model: holds the pushbutton for a commanded number of cycles.
`timescale 1ns/1ps
module fpb_operator (
  input  wire logic        aclk,
  input  wire logic        press_go,
  input  wire logic [15:0] press_cyc,
  output logic             button_in,
  output logic             busy
);
  logic [15:0] left_reg = 16'h0000;
  assign busy = left_reg != 16'h0000;
  // The contacts chatter for 64 cycles at each end, well inside the debounce window.
  assign button_in = busy && ((left_reg >= 16'h0040 && press_cyc - left_reg >= 16'h0040) || left_reg[2]);
  always_ff @(posedge aclk) begin
    if (press_go && !busy) begin
      left_reg <= press_cyc;
    end else if (busy) begin
      left_reg <= left_reg - 16'h0001;
    end
  end
endmodule : fpb_operator

// File: testbench/front_panel_button_alarm_led_bench.sv
// Self-checking bench of the front-panel controller.
`timescale 1ns/1ps
`include "fpb_consts.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module front_panel_button_alarm_led_bench;
  import fpb_pkg::*;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, batt_low = 0, fault = 0, mem_full = 0, press_go = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, op_busy;
  logic        button_in, power_en, erase_log, beeper, led_red, led_green;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, temp_c = 0, mem_fill = 0;
  logic [7:0]  head_type = 8'h05, head_fw_rev = 8'h21, head_channels = 8'h0f;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, log_rd_data, head_serial = 32'h5a5a1234;
  logic [15:0] batt_mv = 16'h0e10, log_count = 16'h0002, log_rd_addr, press_cyc = 0;
  fpb_mode_t   mode;
  int          errors = 0, cmp_count = 0;
  assign log_rd_data = {16'hc0de, log_rd_addr};
  fpb_top #(.TICK_CYCLES(10), .LONG_MS(50)) dut_u (.*);
  fpb_operator op_u (.aclk(aclk), .press_go(press_go), .press_cyc(press_cyc), .button_in(button_in), .busy(op_busy));
  initial forever #5 aclk = ~aclk;
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw = 0, w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= d; s_axi_wvalid <= 1; s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awready) begin aw = 1; s_axi_awvalid <= 0; end
      if (s_axi_wready) begin w = 1; s_axi_wvalid <= 0; end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    `CHK(s_axi_bresp, 2'b00)
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'b00);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    `CHK(s_axi_rdata, e)
    `CHK(s_axi_rresp, er)
  endtask : rd
  task automatic go(input int ms);
    @(posedge aclk);
    while (op_busy) @(posedge aclk);
    press_cyc <= 16'(ms * 10); press_go <= 1;
    @(posedge aclk);
    press_go <= 0;
  endtask : go
  // Short press: the mode changes only once the release has been debounced.
  task automatic short_to(input fpb_mode_t m, input logic er);
    go(40);
    for (int i = 0; i < 1000 && mode !== m; i++) @(posedge aclk);
    `CHK(mode, m)
    `CHK(erase_log, er)
    repeat (11) @(posedge aclk);
    `CHK(beeper, 1'b1)
    repeat (700) @(posedge aclk);
    `CHK(beeper, 1'b0)
    `CHK(mode, m)
  endtask : short_to
  task automatic led_cnt(input int n, input int er, input int eg);
    int r = 0, g = 0;
    repeat (n) begin @(posedge aclk); r += led_red; g += led_green; end
    `CHK(r >= er - 20 && r <= er + 20 && g >= eg - 20 && g <= eg + 20, 1'b1)
  endtask : led_cnt
  initial begin
    #900000;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    `CHK(mode, FPB_OFF)
    rd(`FPB_REG_OVERTEMP, {24'h0, `FPB_OVERTEMP_RST});
    rd(`FPB_REG_CONFIG, {8'h0, `FPB_CHAN_RST, `FPB_RATE_RST});
    short_to(FPB_STANDBY, 1'b0);
    mem_fill <= 8'h40;
    led_cnt(10000, 2500, 0);
    mem_full <= 1;
    led_cnt(10000, 10000, 0);
    mem_full <= 0; mem_fill <= 8'h80;
    short_to(FPB_RUN, 1'b1);
    led_cnt(10000, 0, 5000);
    batt_low <= 1;
    repeat (50) @(posedge aclk);
    `CHK(beeper, 1'b1)
    repeat (300) @(posedge aclk);
    `CHK(beeper, 1'b0)
    batt_low <= 0; temp_c <= 8'h28;
    wr(`FPB_REG_OVERTEMP, 32'h28);
    repeat (100) @(posedge aclk);
    `CHK(beeper, 1'b0)
    temp_c <= 8'h29;
    repeat (1000) @(posedge aclk);
    `CHK(beeper, 1'b1)
    repeat (1000) @(posedge aclk);
    `CHK(beeper, 1'b0)
    repeat (13100) @(posedge aclk);
    `CHK(beeper, 1'b1)
    temp_c <= 8'h00;
    repeat (20) @(posedge aclk);
    temp_c <= 8'h29; fault <= 1;
    repeat (1200) @(posedge aclk);
    `CHK(beeper, 1'b0)
    repeat (900) @(posedge aclk);
    `CHK(beeper, 1'b1)
    led_cnt(2000, 0, 1000);
    fault <= 0; temp_c <= 8'h19;
    wr(`FPB_REG_CTRL, 32'h1);
    wr(`FPB_REG_CONFIG, 32'h00030064);
    rd(`FPB_REG_STATE, 32'h000000a2);
    rd(`FPB_REG_UNIT_ID, 32'h00001001);
    rd(`FPB_REG_UNIT_SERIAL, 32'h1);
    rd(`FPB_REG_HEAD_ID, 32'h000f2105);
    rd(`FPB_REG_HEAD_SERIAL, head_serial);
    rd(`FPB_REG_SNAP_ENV, 32'h0e100019);
    rd(8'h3c, 32'h0, 2'b10);
    wr(`FPB_REG_CTRL, 32'h2);
    for (int i = 0; i < 6; i++) begin
      rd(`FPB_REG_UPLOAD, i == 0 ? 32'h00030064 : i == 1 ? 32'h28 : i == 2 ? 32'h1001 : i == 3 ? 32'h000f2105 :
         {16'hc0de, 16'(i - 4)});
    end
    short_to(FPB_STANDBY, 1'b0);
    go(200);
    repeat (400) @(posedge aclk);
    `CHK(beeper, 1'b1)
    repeat (1400) @(posedge aclk);
    `CHK(beeper, 1'b0)
    `CHK(mode, FPB_OFF)
    repeat (600) @(posedge aclk);
    `CHK({mode, power_en}, {FPB_OFF, 1'b0})
    give_verdict();
  end
endmodule : front_panel_button_alarm_led_bench
